// file: timed_trigger_map.svh
// Register offsets, fields, reset values and timing
`ifndef TIMED_TRIGGER_MAP_SVH
`define TIMED_TRIGGER_MAP_SVH

// ==========================================================
// Register byte offsets (16-bit registers)
`define TTW_OFS_TGT_NS_LO    10'h220
`define TTW_OFS_TGT_NS_HI    10'h222
`define TTW_OFS_TGT_SEC_LO   10'h224
`define TTW_OFS_TGT_SEC_HI   10'h226
`define TTW_OFS_CFG          10'h228
`define TTW_OFS_PULSE_WIDTH  10'h22a
`define TTW_OFS_CYCLE_LO     10'h22c
`define TTW_OFS_CYCLE_HI     10'h22e
`define TTW_OFS_COUNT        10'h230
`define TTW_OFS_PATTERN      10'h232
`define TTW_OFS_CTRL         10'h240
`define TTW_OFS_STATUS       10'h242

// ==========================================================
// Field positions in the configuration register
`define TTW_CFG_CASCADE_BIT  15
`define TTW_CFG_TAIL_BIT     14
`define TTW_CFG_UPSTR_MSB    13
`define TTW_CFG_UPSTR_LSB    10
`define TTW_CFG_TRIGNOW_BIT  9
`define TTW_CFG_NOTIFY_BIT   8
`define TTW_CFG_MODE_MSB     6
`define TTW_CFG_MODE_LSB     4
`define TTW_CFG_PIN_MSB      3
`define TTW_CFG_PIN_LSB      0

// Control and status fields
`define TTW_CTRL_ARM_BIT     0
`define TTW_CTRL_MASK_BIT    1
`define TTW_STAT_DONE_BIT    0
`define TTW_STAT_FAULT_BIT   1
`define TTW_STAT_BUSY_BIT    2

// ==========================================================
// Reset values
`define TTW_RST_WORD         16'h0000
`define TTW_RST_UPSTREAM     4'hf
`define TTW_RST_PIN          4'h0

// ==========================================================
// Timing figures in nanoseconds, and the pin count
`define TTW_CLK_PERIOD_NS    10
`define TTW_PULSE_UNIT_NS    8
`define TTW_CYCLE_UNIT_NS    1
`define TTW_PIN_COUNT        7

`endif

// file: timed_trigger_pkg.sv
// Types shared by the timed trigger waveform unit
package timed_trigger_pkg;

  // Waveform select codes
  typedef enum logic [2:0] {
    FALLING_STEP_MODE   = 3'h0,
    RISING_STEP_MODE    = 3'h1,
    LOW_PULSE_MODE      = 3'h2,
    HIGH_PULSE_MODE     = 3'h3,
    LOW_PERIODIC_MODE   = 3'h4,
    HIGH_PERIODIC_MODE  = 3'h5,
    BIT_PATTERN_MODE    = 3'h6,
    RESERVED_MODE       = 3'h7
  } waveMode_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_RUN  = 4'h4,
    ST_DONE = 4'h8
  } unitState_t;

endpackage

// file: ns_elapsed_timer.sv
// Elapsed-time counter in nanoseconds, advanced by one clock period per edge
`timescale 1ns/100ps

module ns_elapsed_timer #(
  parameter int unsigned W    = 33,
  parameter int unsigned STEP = 10
) (
  input  wire logic         clk,      // System time clock
  input  wire logic         rst_n,    // Synchronous reset, active low
  input  wire logic         restart,  // Zero the count on the next edge
  output logic      [W-1:0] elapsed   // Nanoseconds since last restart
);

  localparam logic [W-1:0] STEP_W = W'(STEP);
  localparam logic [W-1:0] MAX_W  = '1;

  // ==========================================================
  // Counter; saturates so a very long phase never wraps to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      elapsed <= '0;
    end else if (restart) begin
      elapsed <= '0;
    end else if (elapsed <= MAX_W - STEP_W) begin
      elapsed <= elapsed + STEP_W;
    end
  end

endmodule

// file: timed_trigger_waveform_unit.sv
// Timed trigger unit: fires a waveform on a pin at a target time
//
// Notes on behaviour
// RQ1: No trigger-now: wait for system time to reach the target.
// RQ2: Trigger-now with a past target fires at once.
// RQ3: Notify reports done and fault, irq if mask set; else none.
// RQ4: Mode field bits 6-4, reset 000, picks the waveform.
// RQ5: Code 000 idles high, steps low at trigger, stays low.
// RQ6: Code 001 idles low, steps high at trigger, stays high.
// RQ7: Code 010 idles high, pulses low for pulse width.
// RQ8: Code 011 idles low, pulses high for pulse width.
// RQ9: Code 100: low phase pulse, period cycle width, count periods.
// RQ10: Code 101: high phase pulse, period cycle width, count periods.
// RQ11: Code 110 shifts 16-bit pattern, count bits; 111 reserved.
// RQ12: Pattern goes out LSB first and wraps to bit zero.
// RQ13: Software keeps toggling at or below 12.5 MHz.
// RQ14: Pin field bits 3:0 picks pin 0-6; 7 and up none.
// RQ15: Units sharing a pin combine by logical OR.
// RQ16: Pulse width register counts in 8 ns steps.
// RQ17: Cascade tail in pattern mode runs pulse width plus one passes.
// RQ18: Cascade without tail ignores the count, repeats forever; each pass still restarts from bit zero after count bits.
// RQ19: 32-bit cycle width in 1 ns units, also pattern bit time.
// RQ20: Before firing and after finishing, drive the resting level; codes 000 and 001 keep their stepped level after finishing.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "timed_trigger_map.svh"

module timed_trigger_waveform_unit (
  input  wire logic        clk,         // System time clock, 100 MHz
  input  wire logic        rst_n,       // Synchronous reset, active low
  input  wire logic [9:0]  regAddr,     // Register byte address
  input  wire logic [15:0] regWdata,    // Register write data
  input  wire logic        regWr,       // Write strobe
  input  wire logic        regRd,       // Read strobe
  output logic      [15:0] regRdata,    // Read data, cycle after strobe
  input  wire logic [31:0] sysTimeSec,  // System time, seconds
  input  wire logic [31:0] sysTimeNs,   // System time, nanoseconds
  input  wire logic [6:0]  peerPinIn,   // Other units' pin contributions
  output logic      [6:0]  gpioOut,     // Combined trigger pin levels
  output logic             irqOut       // Host interrupt, level
);

  localparam int unsigned TW = 33;
  localparam logic [TW-1:0] CLK_NS = TW'(`TTW_CLK_PERIOD_NS);
  localparam logic [18:0] PW_UNIT = 19'(`TTW_PULSE_UNIT_NS);
  localparam logic [31:0] CW_UNIT = 32'(`TTW_CYCLE_UNIT_NS);

  // ==========================================================
  // Register state
  logic [31:0] tgtNs_q;
  logic [31:0] tgtSec_q;
  logic        cascadeEn_q, tailUnit_q, trigNow_q, notify_q;
  logic [3:0]  upstreamSel_q;
  logic [2:0]  mode_q;
  logic [3:0]  pinSel_q;
  logic [15:0] pulseWidth_q;
  logic [31:0] cycleWidth_q;
  logic [15:0] cycleCount_q;
  logic [15:0] pattern_q;
  logic        unitArm_q, irqMask_q, completeFlag_q, faultFlag_q;

  // Sequencer state
  timed_trigger_pkg::unitState_t state_q;
  logic        activeQ_q, lateQ_q;
  logic [15:0] periodCnt_q, bitsSent_q, passCnt_q;
  logic [3:0]  bitIdx_q;

  // Combinational helpers
  logic [TW-1:0] elapsedNs, pulseNs, cycleNs;
  logic          timerRestart, pulseEnd, periodEnd, lastPeriod, lastBit;
  logic          lastPass, fireNow, missEvt, badMode, runFinish, doneEvt;
  logic          faultEvt, targetReached, targetLate, wrCtrl, armRise;
  logic          armFall, idleHigh, outLvl;
  logic [6:0]    ownPins;
  logic [3:0]    bitIdxNext;

  // ==========================================================
  // Bus decode for the control register, which drives arming
  assign wrCtrl  = regWr && (regAddr == `TTW_OFS_CTRL);
  assign armRise = wrCtrl && regWdata[`TTW_CTRL_ARM_BIT] && !unitArm_q;
  assign armFall = wrCtrl && !regWdata[`TTW_CTRL_ARM_BIT];

  // Configuration registers written by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tgtNs_q       <= {2{`TTW_RST_WORD}};
      tgtSec_q      <= {2{`TTW_RST_WORD}};
      cascadeEn_q   <= 1'b0;
      tailUnit_q    <= 1'b0;
      upstreamSel_q <= `TTW_RST_UPSTREAM;
      trigNow_q     <= 1'b0;
      notify_q      <= 1'b0;
      mode_q        <= 3'h0;
      pinSel_q      <= `TTW_RST_PIN;
      pulseWidth_q  <= `TTW_RST_WORD;
      cycleWidth_q  <= {2{`TTW_RST_WORD}};
      cycleCount_q  <= `TTW_RST_WORD;
      pattern_q     <= `TTW_RST_WORD;
      unitArm_q     <= 1'b0;
      irqMask_q     <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        `TTW_OFS_TGT_NS_LO:   tgtNs_q[15:0]   <= regWdata;
        `TTW_OFS_TGT_NS_HI:   tgtNs_q[31:16]  <= regWdata;
        `TTW_OFS_TGT_SEC_LO:  tgtSec_q[15:0]  <= regWdata;
        `TTW_OFS_TGT_SEC_HI:  tgtSec_q[31:16] <= regWdata;
        `TTW_OFS_CFG: begin
          cascadeEn_q   <= regWdata[`TTW_CFG_CASCADE_BIT];
          tailUnit_q    <= regWdata[`TTW_CFG_TAIL_BIT];
          upstreamSel_q <= regWdata[`TTW_CFG_UPSTR_MSB:`TTW_CFG_UPSTR_LSB];
          trigNow_q     <= regWdata[`TTW_CFG_TRIGNOW_BIT];
          notify_q      <= regWdata[`TTW_CFG_NOTIFY_BIT];
          mode_q        <= regWdata[`TTW_CFG_MODE_MSB:`TTW_CFG_MODE_LSB]; // RQ4
          pinSel_q      <= regWdata[`TTW_CFG_PIN_MSB:`TTW_CFG_PIN_LSB];
        end
        `TTW_OFS_PULSE_WIDTH: pulseWidth_q        <= regWdata;
        `TTW_OFS_CYCLE_LO:    cycleWidth_q[15:0]  <= regWdata;
        `TTW_OFS_CYCLE_HI:    cycleWidth_q[31:16] <= regWdata;
        `TTW_OFS_COUNT:       cycleCount_q        <= regWdata;
        `TTW_OFS_PATTERN:     pattern_q           <= regWdata;
        `TTW_OFS_CTRL: begin
          unitArm_q <= regWdata[`TTW_CTRL_ARM_BIT];
          irqMask_q <= regWdata[`TTW_CTRL_MASK_BIT];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Sticky status; a hardware set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      completeFlag_q <= 1'b0;
      faultFlag_q    <= 1'b0;
    end else begin
      if (notify_q && doneEvt) begin
        completeFlag_q <= 1'b1; // RQ3
      end else if (regWr && regAddr == `TTW_OFS_STATUS &&
                   regWdata[`TTW_STAT_DONE_BIT]) begin
        completeFlag_q <= 1'b0;
      end
      if (notify_q && faultEvt) begin
        faultFlag_q <= 1'b1; // RQ3
      end else if (regWr && regAddr == `TTW_OFS_STATUS &&
                   regWdata[`TTW_STAT_FAULT_BIT]) begin
        faultFlag_q <= 1'b0;
      end
    end
  end

  // Interrupt follows the status flags through the mask
  assign irqOut = irqMask_q && (completeFlag_q || faultFlag_q); // RQ3

  // Read data, registered; unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        `TTW_OFS_TGT_NS_LO:   regRdata <= tgtNs_q[15:0];
        `TTW_OFS_TGT_NS_HI:   regRdata <= tgtNs_q[31:16];
        `TTW_OFS_TGT_SEC_LO:  regRdata <= tgtSec_q[15:0];
        `TTW_OFS_TGT_SEC_HI:  regRdata <= tgtSec_q[31:16];
        `TTW_OFS_CFG:         regRdata <= {cascadeEn_q, tailUnit_q,
                                           upstreamSel_q, trigNow_q,
                                           notify_q, 1'b0, mode_q,
                                           pinSel_q};
        `TTW_OFS_PULSE_WIDTH: regRdata <= pulseWidth_q;
        `TTW_OFS_CYCLE_LO:    regRdata <= cycleWidth_q[15:0];
        `TTW_OFS_CYCLE_HI:    regRdata <= cycleWidth_q[31:16];
        `TTW_OFS_COUNT:       regRdata <= cycleCount_q;
        `TTW_OFS_PATTERN:     regRdata <= pattern_q;
        `TTW_OFS_CTRL:        regRdata <= {14'h0000, irqMask_q, unitArm_q};
        `TTW_OFS_STATUS:      regRdata <= {13'h0000,
                                           state_q == timed_trigger_pkg::ST_RUN,
                                           faultFlag_q, completeFlag_q};
        default:              regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Target comparison against the system time
  assign targetReached = {sysTimeSec, sysTimeNs} >= {tgtSec_q, tgtNs_q};
  assign targetLate    = {sysTimeSec, sysTimeNs} >  {tgtSec_q, tgtNs_q};

  // Phase lengths in ns; pulse width steps 8 ns, cycle width steps 1 ns
  assign pulseNs = TW'(19'(pulseWidth_q) * PW_UNIT); // RQ16
  assign cycleNs = TW'(cycleWidth_q * CW_UNIT); // RQ19
  // Ends are seen one period early so each phase lasts its whole span
  assign pulseEnd  = (elapsedNs + CLK_NS) >= pulseNs;
  assign periodEnd = (elapsedNs + CLK_NS) >= cycleNs;

  ns_elapsed_timer #(
    .W    (TW),
    .STEP (`TTW_CLK_PERIOD_NS)
  ) phaseTimer (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (timerRestart),
    .elapsed (elapsedNs)
  );

  // ==========================================================
  // Firing decision; a late target needs trigger-now, else it is a fault
  assign fireNow = (state_q == timed_trigger_pkg::ST_WAIT) &&
                   (lateQ_q ? trigNow_q : targetReached); // RQ1 RQ2
  assign missEvt = (state_q == timed_trigger_pkg::ST_WAIT) && lateQ_q &&
                   !trigNow_q;
  assign badMode = mode_q == timed_trigger_pkg::RESERVED_MODE; // RQ11
  assign faultEvt = missEvt || (fireNow && badMode);

  // Count ends; a zero count never ends
  assign lastPeriod = (cycleCount_q != 16'h0000) &&
                      (periodCnt_q + 16'h0001 == cycleCount_q); // RQ9 RQ10
  assign lastBit    = (cycleCount_q != 16'h0000) &&
                      (bitsSent_q + 16'h0001 == cycleCount_q); // RQ11
  // Cascade tail repeats value+1 passes; cascade with no tail never stops
  assign lastPass   = !cascadeEn_q ||
                      (tailUnit_q && passCnt_q == pulseWidth_q); // RQ17 RQ18
  assign bitIdxNext = bitIdx_q + 4'h1; // RQ12

  // Completion of the running waveform
  always_comb begin
    case (timed_trigger_pkg::waveMode_t'(mode_q))
      timed_trigger_pkg::FALLING_STEP_MODE,
      timed_trigger_pkg::RISING_STEP_MODE:   runFinish = 1'b1;
      timed_trigger_pkg::LOW_PULSE_MODE,
      timed_trigger_pkg::HIGH_PULSE_MODE:    runFinish = pulseEnd;
      timed_trigger_pkg::LOW_PERIODIC_MODE,
      timed_trigger_pkg::HIGH_PERIODIC_MODE: runFinish = periodEnd &&
                                                         lastPeriod;
      timed_trigger_pkg::BIT_PATTERN_MODE:   runFinish = periodEnd && lastBit
                                                         && lastPass;
      default:                               runFinish = 1'b1;
    endcase
  end
  assign doneEvt = (state_q == timed_trigger_pkg::ST_RUN) && runFinish;

  // Timer restarts at firing and at every period or bit boundary
  assign timerRestart = (fireNow && !badMode) ||
                        ((state_q == timed_trigger_pkg::ST_RUN) && periodEnd);

  // ==========================================================
  // Sequencer: arm, wait for target, run waveform, rest
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= timed_trigger_pkg::ST_IDLE;
      activeQ_q   <= 1'b0;
      lateQ_q     <= 1'b0;
      periodCnt_q <= 16'h0000;
      bitsSent_q  <= 16'h0000;
      bitIdx_q    <= 4'h0;
      passCnt_q   <= 16'h0000;
    end else if (armFall) begin
      state_q   <= timed_trigger_pkg::ST_IDLE;
      activeQ_q <= 1'b0; // RQ20
    end else if (armRise) begin
      state_q   <= timed_trigger_pkg::ST_WAIT;
      activeQ_q <= 1'b0;
      lateQ_q   <= targetLate;
    end else begin
      case (state_q)
        timed_trigger_pkg::ST_IDLE: begin
          activeQ_q <= 1'b0; // RQ20
        end
        timed_trigger_pkg::ST_WAIT: begin
          if (faultEvt) begin
            state_q <= timed_trigger_pkg::ST_IDLE;
          end else if (fireNow) begin
            state_q     <= timed_trigger_pkg::ST_RUN;
            periodCnt_q <= 16'h0000;
            bitsSent_q  <= 16'h0000;
            bitIdx_q    <= 4'h0;
            passCnt_q   <= 16'h0000;
            // Pattern starts on its bit zero, all others go active
            activeQ_q <= (mode_q == timed_trigger_pkg::BIT_PATTERN_MODE) ?
                         pattern_q[0] : 1'b1; // RQ5 RQ6 RQ12
          end
        end
        timed_trigger_pkg::ST_RUN: begin
          if (runFinish) begin
            state_q <= timed_trigger_pkg::ST_DONE;
            // Steps hold their new level; everything else comes to rest
            activeQ_q <= (mode_q == timed_trigger_pkg::FALLING_STEP_MODE) ||
                         (mode_q == timed_trigger_pkg::RISING_STEP_MODE);
          end else if (mode_q == timed_trigger_pkg::BIT_PATTERN_MODE) begin
            if (periodEnd) begin
              if (lastBit) begin
                // Next pass restarts from bit zero
                passCnt_q  <= passCnt_q + 16'h0001; // RQ17
                bitsSent_q <= 16'h0000;
                bitIdx_q   <= 4'h0;
                activeQ_q  <= pattern_q[0];
              end else begin
                bitsSent_q <= bitsSent_q + 16'h0001;
                bitIdx_q   <= bitIdxNext; // RQ12
                activeQ_q  <= pattern_q[bitIdxNext]; // RQ11
              end
            end
          end else if (periodEnd && mode_q[2]) begin
            periodCnt_q <= periodCnt_q + 16'h0001; // RQ9 RQ10
            activeQ_q   <= 1'b1;
          end else if (pulseEnd) begin
            activeQ_q <= 1'b0; // RQ7 RQ8 RQ9 RQ10
          end
        end
        timed_trigger_pkg::ST_DONE: begin
          state_q <= timed_trigger_pkg::ST_DONE; // RQ20
        end
        default: begin
          state_q   <= timed_trigger_pkg::ST_IDLE;
          activeQ_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Output level: falling-type modes idle high, so invert the active flag
  assign idleHigh = (mode_q == timed_trigger_pkg::FALLING_STEP_MODE) ||
                    (mode_q == timed_trigger_pkg::LOW_PULSE_MODE) ||
                    (mode_q == timed_trigger_pkg::LOW_PERIODIC_MODE);
  assign outLvl = activeQ_q ^ idleHigh; // RQ5 RQ6 RQ7 RQ8 RQ20

  // Pin routing; select values seven and above drive nothing
  always_comb begin
    ownPins = 7'h00;
    for (int i = 0; i < `TTW_PIN_COUNT; i++) begin
      if (pinSel_q == 4'(i)) begin
        ownPins[i] = outLvl; // RQ14
      end
    end
  end

  // Registered pins; peers sharing a pin are combined by OR
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpioOut <= 7'h00;
    end else begin
      gpioOut <= ownPins | peerPinIn; // RQ15
    end
  end

endmodule

// file: sys_time_peer.sv
// Far-side model: system time source and the other units' pin levels
`timescale 1ns/100ps
module sys_time_peer (
  input  wire logic        clk,        // System time clock
  input  wire logic        rst_n,      // Synchronous reset, active low
  input  wire logic [6:0]  peerMask,   // Levels other units drive
  output logic      [31:0] sysTimeSec, // Seconds
  output logic      [31:0] sysTimeNs,  // Nanoseconds
  output logic      [6:0]  peerPinIn   // Registered peer levels
);
  // ==========================================================
  // Time base and peer levels
  // A run lasts far less than a second, so seconds never roll over
  assign sysTimeSec = 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sysTimeNs <= 32'h0000_0000;
      peerPinIn <= 7'h00;
    end else begin
      sysTimeNs <= sysTimeNs + 32'h0000_000a;
      peerPinIn <= peerMask;
    end
  end
endmodule

// file: timed_trigger_waveform_unit_asserts.sv
// Port-level checks for the timed trigger waveform unit
`timescale 1ns/100ps
`include "timed_trigger_map.svh"
module timed_trigger_waveform_unit_asserts (
  input wire logic        clk,       // Clock
  input wire logic        rst_n,     // Reset
  input wire logic [9:0]  regAddr,   // Address
  input wire logic [15:0] regWdata,  // Write data
  input wire logic        regWr,     // Write
  input wire logic        regRd,     // Read
  input wire logic [15:0] regRdata,  // Read data
  input wire logic [6:0]  peerPinIn, // Peer levels
  input wire logic [6:0]  gpioOut,   // Pins
  input wire logic        irqOut     // Interrupt
);
  // ==========================================================
  // Shadow of the fields the checks depend on
  logic [15:0] cfgQ, pwQ;
  logic        armQ, maskQ, restHi, ctlWr;
  logic [1:0]  calmQ;
  logic [2:0]  pin;
  assign pin    = cfgQ[2:0];
  assign restHi = cfgQ[6:4] inside {3'h0, 3'h2, 3'h4};
  assign ctlWr  = regWr && (regAddr == `TTW_OFS_CFG ||
                            regAddr == `TTW_OFS_CTRL);
  // Calm counts quiet cycles, so the pin has settled after a write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgQ  <= 16'h3c00;
      pwQ   <= 16'h0000;
      {maskQ, armQ} <= 2'h0;
      calmQ <= 2'h0;
    end else begin
      if (regWr && regAddr == `TTW_OFS_CFG)
        cfgQ <= regWdata;
      if (regWr && regAddr == `TTW_OFS_PULSE_WIDTH)
        pwQ <= regWdata;
      if (regWr && regAddr == `TTW_OFS_CTRL)
        {maskQ, armQ} <= regWdata[1:0];
      calmQ <= ctlWr ? 2'h0 : calmQ + {1'b0, calmQ != 2'h3};
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  pw_readback_a: assert property (
    regWr && regAddr == `TTW_OFS_PULSE_WIDTH ##2
    regRd && regAddr == `TTW_OFS_PULSE_WIDTH |=>
    regRdata == $past(regWdata, 3)) else $error("pulse width readback");
  cfg_read_a: assert property (
    regRd && regAddr == `TTW_OFS_CFG |=>
    regRdata == ($past(cfgQ) & 16'hff7f)) else $error("config readback");
  pin_none_a: assert property (
    cfgQ[3:0] > 4'h6 && $past(cfgQ[3:0]) > 4'h6 |->
    gpioOut == $past(peerPinIn)) else $error("unselected pin driven");
  peer_or_a: assert property (
    (gpioOut & $past(peerPinIn)) == $past(peerPinIn))
    else $error("peer level lost");
  rest_level_a: assert property (
    calmQ == 2'h3 && !armQ && cfgQ[3:0] < 4'h7 |->
    gpioOut[pin] == (restHi | $past(peerPinIn[pin])))
    else $error("wrong resting level");
  irq_mask_a: assert property (
    !maskQ |-> !irqOut) else $error("interrupt while masked");
  hi_pulse_a: assert property (
    $rose(gpioOut[pin]) && cfgQ[6:4] == 3'h3 && pwQ == 16'h0005 &&
    peerPinIn == 7'h00 |-> gpioOut[pin] [*4] ##1 !gpioOut[pin])
    else $error("high pulse width wrong");
  lo_pulse_a: assert property (
    $fell(gpioOut[pin]) && cfgQ[6:4] == 3'h2 && pwQ == 16'h0005 &&
    peerPinIn == 7'h00 |-> !gpioOut[pin] [*4] ##1 gpioOut[pin])
    else $error("low pulse width wrong");
  cover property (irqOut);
  cover property ($rose(gpioOut[pin]) && cfgQ[6:4] == 3'h6);
  cover property (cfgQ[3:0] > 4'h6 && peerPinIn != 7'h00);
endmodule

// file: timed_trigger_waveform_unit_tb_top.sv
// Self-checking bench for the timed trigger waveform unit
`timescale 1ns/100ps
`include "timed_trigger_map.svh"
module timed_trigger_waveform_unit_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [9:0]  regAddr = 10'h000;
  logic [15:0] regWdata = 16'h0000;
  logic [6:0]  peerMask = 7'h00;
  logic [15:0] regRdata, rd;
  logic [31:0] sysTimeSec, sysTimeNs;
  logic [6:0]  peerPinIn, gpioOut;
  logic        irqOut;
  int          miscompares = 0;
  int          checks_done = 0;

  // ==========================================================
  // Clock, far side and device
  initial begin
    forever #5 clk = ~clk;
  end
  sys_time_peer i_sys_time_peer (.clk(clk), .rst_n(rst_n),
    .peerMask(peerMask), .sysTimeSec(sysTimeSec), .sysTimeNs(sysTimeNs),
    .peerPinIn(peerPinIn));
  timed_trigger_waveform_unit i_timed_trigger_waveform_unit (.clk(clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .sysTimeSec(sysTimeSec),
    .sysTimeNs(sysTimeNs), .peerPinIn(peerPinIn), .gpioOut(gpioOut),
    .irqOut(irqOut));

  // ==========================================================
  // Helpers
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [9:0] a, logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rdv(logic [9:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic setup(logic [15:0] cfg, pw, cnt, pat, logic [31:0] tgt);
    wr(`TTW_OFS_PULSE_WIDTH, pw);
    wr(`TTW_OFS_CYCLE_LO, 16'h0050);
    wr(`TTW_OFS_CYCLE_HI, 16'h0000);
    wr(`TTW_OFS_COUNT, cnt);
    wr(`TTW_OFS_PATTERN, pat);
    wr(`TTW_OFS_TGT_NS_LO, tgt[15:0]);
    wr(`TTW_OFS_TGT_NS_HI, tgt[31:16]);
    wr(`TTW_OFS_CFG, cfg);
  endtask
  // Expected level i cycles after firing; 80 ns cycle width throughout
  function automatic logic lvl(int m, i, pw, cnt, pass, logic [15:0] pat);
    int pc, n;
    logic live;
    pc   = (pw * 8 + 9) / 10;
    n    = i / 8;
    live = cnt == 0 || pass == 0 || n < cnt * pass;
    case (m)
      0: return 1'b0;
      1: return 1'b1;
      2: return i >= pc;
      3: return i < pc;
      4: return !(live && i % 8 < pc);
      5: return live && i % 8 < pc;
      default: return live && pat[(cnt != 0 ? n % cnt : n) % 16];
    endcase
  endfunction

  // ==========================================================
  // Scenarios
  task automatic regs();
    rdv(`TTW_OFS_PULSE_WIDTH);
    check("pulse width reset", rd, 16'h0000);
    rdv(`TTW_OFS_CFG);
    check("config reset", rd, 16'h3c00);
    rdv(10'h3fe);
    check("unmapped read", rd, 16'h0000);
    wr(`TTW_OFS_PULSE_WIDTH, 16'ha5c3);
    rdv(`TTW_OFS_PULSE_WIDTH);
    check("pulse width", rd, 16'ha5c3);
    wr(`TTW_OFS_CFG, 16'hffff);
    rdv(`TTW_OFS_CFG);
    check("config", rd, 16'hff7f);
  endtask
  task automatic pins();
    for (int p = 0; p < 16; p++) begin
      wr(`TTW_OFS_CFG, 16'(p));
      tick(3);
      check("pin route", gpioOut, p < 7 ? 7'h01 << p : 7'h00);
    end
    @(posedge clk);
    peerMask <= 7'h41;
    tick(4);
    check("no pin", gpioOut, 7'h41);
    wr(`TTW_OFS_CFG, 16'h0002);
    tick(4);
    check("pin or", gpioOut, 7'h45);
    @(posedge clk);
    peerMask <= 7'h00;
  endtask
  // Target lies 800 ns ahead, so firing early shows as a short wait
  task automatic wave(logic [15:0] cfg, pw, cnt, pat, int pass);
    int m, w;
    logic rest;
    m    = cfg[6:4];
    rest = m == 0 || m == 2 || m == 4;
    wr(`TTW_OFS_CTRL, 16'h0000);
    setup(cfg, pw, cnt, pat, sysTimeNs + 32'd800);
    tick(3);
    check("rest level", gpioOut[2], rest);
    wr(`TTW_OFS_CTRL, 16'h0001);
    w = 0;
    while (gpioOut[2] === rest && w < 200) begin
      tick(1);
      w++;
    end
    if (w == 200) begin
      miscompares++;
      stop_test();
    end
    check("held off", w >= 40, 1'b1);
    for (int i = 0; i < 160; i++) begin
      check("waveform", gpioOut[2], lvl(m, i, pw, cnt, pass, pat));
      tick(1);
    end
  endtask
  // Target zero is already past when armed
  task automatic fire(logic [15:0] cfg, logic [15:0] stat);
    wr(`TTW_OFS_CTRL, 16'h0002);
    wr(`TTW_OFS_STATUS, 16'h0003);
    setup(cfg, 16'h0005, 16'h0000, 16'h0000, 32'h0000_0000);
    wr(`TTW_OFS_CTRL, 16'h0003);
    tick(20);
    rdv(`TTW_OFS_STATUS);
    check("status", rd, stat);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    regs();
    pins();
    // 80 ns cycle widths keep toggling at or below 12.5 MHz
    wave(16'h0002, 16'h0005, 16'h0000, 16'h0000, 1);
    wave(16'h0012, 16'h0005, 16'h0000, 16'h0000, 1);
    wave(16'h0022, 16'h0005, 16'h0000, 16'h0000, 1);
    wave(16'h0032, 16'h0005, 16'h0000, 16'h0000, 1);
    wave(16'h0042, 16'h0005, 16'h0003, 16'h0000, 1);
    wave(16'h0052, 16'h0005, 16'h0000, 16'h0000, 1);
    wave(16'h0062, 16'h0000, 16'h0012, 16'h8001, 1);
    wave(16'hc062, 16'h0001, 16'h0003, 16'h0005, 2);
    wave(16'h8062, 16'h0001, 16'h0003, 16'h0005, 0);
    fire(16'h0332, 16'h0001);
    check("irq raised", irqOut, 1'b1);
    fire(16'h0132, 16'h0002);
    fire(16'h0232, 16'h0000);
    check("irq quiet", irqOut, 1'b0);
    fire(16'h0372, 16'h0002);
    wr(`TTW_OFS_CTRL, 16'h0000);
    tick(2);
    check("irq masked", irqOut, 1'b0);
    stop_test();
  end
endmodule

bind timed_trigger_waveform_unit timed_trigger_waveform_unit_asserts
  i_timed_trigger_waveform_unit_asserts (.clk(clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .peerPinIn(peerPinIn), .gpioOut(gpioOut),
  .irqOut(irqOut));
